/* File: rtl/bbx_exec.sv */
// Byte and bit execute unit with its AXI4-Lite register slave.
// Notes on behaviour
// - Literal add into accumulator sets carry, half carry and zero.
// - Clear bit clears chosen bit of addressed file; flags untouched.
// - Add accumulator and file; flags from that sum.
// - Destination 0 sends result to accumulator, 1 back to file.
// - Set bit sets chosen bit of addressed file; flags untouched.
// - AND literal into accumulator; only zero flag changes.
// - AND accumulator with file to destination; only zero flag changes.
// - Skip if bit zero discards the next instruction as a no-op.
// - Skip if bit one discards the next instruction as a no-op.
// - Port register operand is the pin level, not the latch.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bbx_regs.svh"
module bbx_exec #(
    parameter int DEPTH = 128
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        awvalid,
    output      logic        awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output      logic        wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output      logic        bvalid,
    input  wire logic        bready,
    output      logic [1:0]  bresp,
    input  wire logic        arvalid,
    output      logic        arready,
    input  wire logic [7:0]  araddr,
    output      logic        rvalid,
    input  wire logic        rready,
    output      logic [31:0] rdata,
    output      logic [1:0]  rresp,
    input  wire logic [7:0]  io_in,
    output      logic [7:0]  io_out,
    output      logic [7:0]  io_oe_b
);
    import bbx_pkg::*;

    bbx_st_t    q;
    bbx_st_t    d;
    bbx_fwr_t   fwr;
    logic [7:0] fa;
    logic [7:0] fb;
    logic       commit;
    logic       ex_go;
    bbx_op_t    op;
    logic [7:0] k;
    logic [2:0] bsel;
    logic       dst;
    logic [9:0] sum;

    function automatic bbx_sel_t reg_sel(input logic [7:0] a);
        bbx_sel_t s;
        s = SEL_NONE;
        unique case ({a[7:2], 2'b00})
            `BBX_ACC_OFS:    s = SEL_ACC;
            `BBX_STATUS_OFS: s = SEL_STATUS;
            `BBX_ISSUE_OFS:  s = SEL_ISSUE;
            `BBX_FADDR_OFS:  s = SEL_FADDR;
            `BBX_FDATA_OFS:  s = SEL_FDATA;
            default:         s = SEL_NONE;
        endcase
        return s;
    endfunction

    function automatic logic [9:0] add8(input logic [7:0] a,
                                        input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, b};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        return {full[8], low[4], full[7:0]};
    endfunction

    function automatic logic [7:0] mask8(input logic [2:0] b);
        return 8'h01 << b;
    endfunction

    bbx_fmem #(
        .DEPTH (DEPTH)
    ) u_fmem (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .wr        (fwr),
        .rd_a_addr (q.wdata[`BBX_ISS_F_MSB:0]),
        .rd_a_data (fa),
        .rd_b_addr (q.faddr),
        .rd_b_data (fb),
        .io_in     (io_in),
        .io_out    (io_out),
        .io_oe_b   (io_oe_b)
    );

    always_comb begin
        d      = q;
        fwr    = '0;
        op     = bbx_op_t'(q.wdata[`BBX_ISS_OP_MSB:`BBX_ISS_OP_LSB]);
        k      = q.wdata[`BBX_ISS_K_MSB:0];
        bsel   = q.wdata[`BBX_ISS_BIT_MSB:`BBX_ISS_BIT_LSB];
        dst    = q.wdata[`BBX_ISS_DEST];
        sum    = add8(q.acc, (op == ADD_LITERAL_TO_ACCUMULATOR) ? k : fa);
        commit = q.aw_got && q.w_got && !q.bvalid;
        ex_go  = commit && reg_sel(q.awaddr) == SEL_ISSUE
                 && q.wstrb[1:0] == 2'b11;
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.wdata = wdata;
            d.wstrb = wstrb;
        end
        if (commit) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = (reg_sel(q.awaddr) == SEL_NONE) ?
                       `BBX_RESP_SLVERR : `BBX_RESP_OKAY;
            if (q.wstrb[0]) begin
                unique case (reg_sel(q.awaddr))
                    SEL_ACC:    d.acc = q.wdata[7:0];
                    SEL_STATUS: begin
                        d.c               = q.wdata[`BBX_ST_C];
                        d.half_carry_flag = q.wdata[`BBX_ST_DC];
                        d.z               = q.wdata[`BBX_ST_Z];
                    end
                    SEL_FADDR:  d.faddr = q.wdata[6:0];
                    SEL_FDATA:  fwr = '{1'b1, q.faddr, q.wdata[7:0]};
                    default:    d.acc = q.acc;
                endcase
            end
        end
        if (ex_go) begin
            d.last = q.wdata[15:0];
            if (q.skip) begin
                d.skip = 1'b0;
            end else begin
                unique case (op)
                    ADD_LITERAL_TO_ACCUMULATOR: begin
                        {d.c, d.half_carry_flag, d.acc} = sum;
                        d.z = (sum[7:0] == 8'h00);
                    end
                    AND_LITERAL_WITH_ACCUMULATOR: begin
                        d.acc = q.acc & k;
                        d.z   = ((q.acc & k) == 8'h00);
                    end
                    ADD_ACCUMULATOR_WITH_FILE: begin
                        {d.c, d.half_carry_flag} = sum[9:8];
                        d.z = (sum[7:0] == 8'h00);
                        if (dst) begin
                            fwr = '{1'b1, q.wdata[6:0], sum[7:0]};
                        end else begin
                            d.acc = sum[7:0];
                        end
                    end
                    AND_ACCUMULATOR_WITH_FILE: begin
                        d.z = ((q.acc & fa) == 8'h00);
                        if (dst) begin
                            fwr = '{1'b1, q.wdata[6:0], q.acc & fa};
                        end else begin
                            d.acc = q.acc & fa;
                        end
                    end
                    CLEAR_FILE_BIT:
                        fwr = '{1'b1, q.wdata[6:0], fa & ~mask8(bsel)};
                    SET_FILE_BIT:
                        fwr = '{1'b1, q.wdata[6:0], fa | mask8(bsel)};
                    SKIP_IF_BIT_ZERO: d.skip = ((fa & mask8(bsel)) == 8'h00);
                    SKIP_IF_BIT_ONE:  d.skip = ((fa & mask8(bsel)) != 8'h00);
                    default:          d.skip = 1'b0;
                endcase
            end
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp  = `BBX_RESP_OKAY;
            unique case (reg_sel(araddr))
                SEL_ACC:    d.rdata = {24'h00_0000, q.acc};
                SEL_STATUS: d.rdata = {28'h000_0000, q.skip, q.z,
                                       q.half_carry_flag, q.c};
                SEL_ISSUE:  d.rdata = {16'h0000, q.last};
                SEL_FADDR:  d.rdata = {25'h000_0000, q.faddr};
                SEL_FDATA:  d.rdata = {24'h00_0000, fb};
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = `BBX_RESP_SLVERR;
                end
            endcase
        end
        // One write in flight keeps the commit logic free of queues.
        d.awready = !d.aw_got && !d.bvalid;
        d.wready  = !d.w_got && !d.bvalid;
        d.arready = !d.rvalid;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q         <= '0;
            q.acc     <= `BBX_ACC_RST;
            q.awready <= 1'b1;
            q.wready  <= 1'b1;
            q.arready <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign awready = q.awready;
    assign wready  = q.wready;
    assign bvalid  = q.bvalid;
    assign bresp   = q.bresp;
    assign arready = q.arready;
    assign rvalid  = q.rvalid;
    assign rdata   = q.rdata;
    assign rresp   = q.rresp;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence live_op(bbx_op_t o);
        ex_go && !q.skip && op == o;
    endsequence

    add_literal_a: assert property (
        live_op(ADD_LITERAL_TO_ACCUMULATOR) |=>
        q.acc == 8'($past(q.acc) + $past(k)))
        else $error("literal add result wrong");
    clear_bit_a: assert property (
        live_op(CLEAR_FILE_BIT) |-> fwr.en && !fwr.data[bsel]
        ##1 $stable({q.c, q.half_carry_flag, q.z, q.acc}))
        else $error("clear bit wrong or flags moved");
    add_file_a: assert property (
        live_op(ADD_ACCUMULATOR_WITH_FILE) ##0 !dst |=>
        q.acc == 8'($past(q.acc) + $past(fa)))
        else $error("file add result wrong");
    dest_file_a: assert property (
        ex_go && !q.skip && dst && (op == ADD_ACCUMULATOR_WITH_FILE ||
        op == AND_ACCUMULATOR_WITH_FILE) |-> fwr.en
        && fwr.addr == q.wdata[6:0] ##1 $stable(q.acc))
        else $error("file destination not honoured");
    set_bit_a: assert property (
        live_op(SET_FILE_BIT) |-> fwr.en && fwr.data[bsel]
        ##1 $stable({q.c, q.half_carry_flag, q.z}))
        else $error("set bit wrong or flags moved");
    and_literal_a: assert property (
        live_op(AND_LITERAL_WITH_ACCUMULATOR) |=>
        q.acc == ($past(q.acc) & $past(k)) && $stable(q.c)
        && $stable(q.half_carry_flag))
        else $error("literal and wrong");
    and_file_a: assert property (
        live_op(AND_ACCUMULATOR_WITH_FILE) |=>
        q.z == (($past(q.acc) & $past(fa)) == 8'h00) && $stable(q.c))
        else $error("file and flags wrong");
    skip_zero_a: assert property (
        live_op(SKIP_IF_BIT_ZERO) |=> q.skip == !$past(fa[bsel]))
        else $error("skip on zero wrong");
    skip_one_a: assert property (
        live_op(SKIP_IF_BIT_ONE) |=> q.skip == $past(fa[bsel]))
        else $error("skip on one wrong");
    discard_slot_a: assert property (
        ex_go && q.skip |-> !fwr.en ##1 !q.skip && $stable(q.acc))
        else $error("discarded slot had an effect");
    flag_calc_a: assert property (
        live_op(ADD_LITERAL_TO_ACCUMULATOR) |=>
        q.c == $past(9'(q.acc) + 9'(k)) >> 8
        && q.z == (q.acc == 8'h00))
        else $error("carry or zero flag wrong");
    one_cycle_a: assert property (
        ex_go |=> q.bvalid && !q.aw_got && q.last == $past(q.wdata[15:0]))
        else $error("execute not done in one cycle");

    skip_taken_c: cover property (live_op(SKIP_IF_BIT_ONE) ##1 q.skip);
    carry_out_c:  cover property (live_op(ADD_ACCUMULATOR_WITH_FILE)
                                  ##1 q.c);
    bad_addr_c:   cover property (q.bvalid && q.bresp != 2'b00);
endmodule

/* File: rtl/bbx_regs.svh */
// Register offsets, field positions and reset values of the execute unit.
`ifndef BBX_REGS_SVH
`define BBX_REGS_SVH
`define BBX_ACC_OFS       8'h00
`define BBX_STATUS_OFS    8'h04
`define BBX_ISSUE_OFS     8'h08
`define BBX_FADDR_OFS     8'h0C
`define BBX_FDATA_OFS     8'h10
`define BBX_ST_C          0
`define BBX_ST_DC         1
`define BBX_ST_Z          2
`define BBX_ST_SKIP       3
`define BBX_ISS_OP_MSB    15
`define BBX_ISS_OP_LSB    12
`define BBX_ISS_DEST      11
`define BBX_ISS_BIT_MSB   10
`define BBX_ISS_BIT_LSB   8
`define BBX_ISS_F_MSB     6
`define BBX_ISS_K_MSB     7
`define BBX_ACC_RST       8'h00
`define BBX_DIR_RST       8'hFF
`define BBX_IO_ADDR       7'h05
`define BBX_DIR_ADDR      7'h06
`define BBX_RESP_OKAY     2'b00
`define BBX_RESP_SLVERR   2'b10
`endif

/* File: rtl/bbx_pkg.sv */
// Types shared by the byte and bit execute unit.
package bbx_pkg;
    typedef enum logic [3:0] {
        NO_OPERATION                 = 4'h0,
        ADD_LITERAL_TO_ACCUMULATOR   = 4'h1,
        AND_LITERAL_WITH_ACCUMULATOR = 4'h2,
        ADD_ACCUMULATOR_WITH_FILE    = 4'h3,
        AND_ACCUMULATOR_WITH_FILE    = 4'h4,
        CLEAR_FILE_BIT               = 4'h5,
        SET_FILE_BIT                 = 4'h6,
        SKIP_IF_BIT_ZERO             = 4'h7,
        SKIP_IF_BIT_ONE              = 4'h8
    } bbx_op_t;
    typedef enum logic [2:0] {
        SEL_ACC    = 3'b000,
        SEL_STATUS = 3'b001,
        SEL_ISSUE  = 3'b010,
        SEL_FADDR  = 3'b011,
        SEL_FDATA  = 3'b100,
        SEL_NONE   = 3'b111
    } bbx_sel_t;
    typedef struct packed {
        logic       en;
        logic [6:0] addr;
        logic [7:0] data;
    } bbx_fwr_t;
    typedef struct packed {
        logic [7:0]  acc;
        logic        c;
        logic        half_carry_flag;
        logic        z;
        logic        skip;
        logic [6:0]  faddr;
        logic [15:0] last;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } bbx_st_t;
endpackage

/* File: rtl/bbx_fmem.sv */
// File register storage with the pin-backed input/output register.
`timescale 1ns/1ps
`include "bbx_regs.svh"
module bbx_fmem #(
    parameter int DEPTH = 128
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire bbx_pkg::bbx_fwr_t wr,
    input  wire logic [6:0]       rd_a_addr,
    output      logic [7:0]       rd_a_data,
    input  wire logic [6:0]       rd_b_addr,
    output      logic [7:0]       rd_b_data,
    input  wire logic [7:0]       io_in,
    output      logic [7:0]       io_out,
    output      logic [7:0]       io_oe_b
);
    import bbx_pkg::*;

    if (DEPTH < 8 || DEPTH > 128) begin : g_chk
        $error("bbx_fmem: DEPTH must lie between 8 and 128");
    end

    typedef struct packed {
        logic [DEPTH-1:0][7:0] mem;
        logic [7:0]            s1;
        logic [7:0]            s2;
    } bbx_fm_st_t;

    bbx_fm_st_t q;
    bbx_fm_st_t d;

    // The port register reads the synchronised pins, not its latch.
    function automatic logic [7:0] rd(input logic [6:0] a,
                                      input bbx_fm_st_t s);
        logic [7:0] v;
        v = 8'h00;
        if (a == `BBX_IO_ADDR) begin
            v = s.s2;
        end else if (32'(a) < DEPTH) begin
            v = s.mem[a];
        end
        return v;
    endfunction

    always_comb begin
        d    = q;
        d.s1 = io_in;
        d.s2 = q.s1;
        if (wr.en && 32'(wr.addr) < DEPTH) begin
            d.mem[wr.addr] = wr.data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q                 <= '0;
            q.mem[`BBX_DIR_ADDR] <= `BBX_DIR_RST;
        end else begin
            q <= d;
        end
    end

    assign rd_a_data = rd(rd_a_addr, q);
    assign rd_b_data = rd(rd_b_addr, q);
    assign io_out    = q.mem[`BBX_IO_ADDR];
    assign io_oe_b   = q.mem[`BBX_DIR_ADDR];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    pin_read_a: assert property (
        (rd_a_addr == `BBX_IO_ADDR) |-> (rd_a_data == $past(io_in, 2)))
        else $error("port read does not follow the pins");
endmodule

/* File: dv/bbx_exec_tb.sv */
// Self-checking bench for the byte and bit execute unit.
`timescale 1ns/1ps
`include "bbx_regs.svh"
module bbx_exec_tb;
    import bbx_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic        awvalid = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic        wvalid  = 1'b0;
    logic [31:0] wdata   = 32'h0000_0000;
    logic [3:0]  wstrb   = 4'hf;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        rready  = 1'b0;
    logic [7:0]  io_in   = 8'h00;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [7:0]  io_out, io_oe_b;
    int          error_cnt = 0;
    int          tests_run = 0;

    bbx_exec #(.DEPTH(128)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .io_in(io_in), .io_out(io_out), .io_oe_b(io_oe_b)
    );

    always #50 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address and data are offered together; each is released once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        r = 2'b11;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (bvalid === 1'b1 && aw_ok && w_ok) begin
                r = bresp;
                break;
            end
            if (awready === 1'b1 && !aw_ok) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w_ok) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        bit ar_ok;
        ar_ok = 0;
        d = 32'hdead_beef;
        r = 2'b11;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (rvalid === 1'b1 && ar_ok) begin
                d = rdata;
                r = rresp;
                break;
            end
            if (arready === 1'b1 && !ar_ok) begin
                ar_ok = 1;
                arvalid <= 1'b0;
            end
        end
        rready <= 1'b0;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk({30'h0, r}, {30'h0, `BBX_RESP_OKAY});
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(d, exp);
        chk({30'h0, r}, {30'h0, `BBX_RESP_OKAY});
    endtask

    task automatic issue(input bbx_op_t op, input logic dst,
                         input logic [2:0] b, input logic [7:0] k);
        wreg(`BBX_ISSUE_OFS, {16'h0000, op, dst, b, k});
    endtask

    task automatic t_reset;
        rchk(`BBX_ACC_OFS, 32'h0000_0000);
        rchk(`BBX_STATUS_OFS, 32'h0000_0000);
        chk({24'h0, io_oe_b}, 32'h0000_00ff);
        chk({24'h0, io_out}, 32'h0000_0000);
    endtask

    task automatic t_add_lit;
        wreg(`BBX_ACC_OFS, 32'h0000_008f);
        issue(ADD_LITERAL_TO_ACCUMULATOR, 1'b0, 3'h0, 8'h71);
        rchk(`BBX_ACC_OFS, 32'h0000_0000);
        rchk(`BBX_STATUS_OFS, 32'h0000_0007);
        issue(ADD_LITERAL_TO_ACCUMULATOR, 1'b0, 3'h0, 8'hff);
        rchk(`BBX_ACC_OFS, 32'h0000_00ff);
        rchk(`BBX_STATUS_OFS, 32'h0000_0000);
        rchk(`BBX_ISSUE_OFS, 32'h0000_10ff);
    endtask

    task automatic t_and_lit;
        wreg(`BBX_ACC_OFS, 32'h0000_003c);
        wreg(`BBX_STATUS_OFS, 32'h0000_0003);
        issue(AND_LITERAL_WITH_ACCUMULATOR, 1'b0, 3'h0, 8'hc3);
        rchk(`BBX_ACC_OFS, 32'h0000_0000);
        rchk(`BBX_STATUS_OFS, 32'h0000_0007);
        wreg(`BBX_ACC_OFS, 32'h0000_003c);
        issue(AND_LITERAL_WITH_ACCUMULATOR, 1'b0, 3'h0, 8'hff);
        rchk(`BBX_STATUS_OFS, 32'h0000_0003);
    endtask

    task automatic t_file;
        wreg(`BBX_FADDR_OFS, 32'h0000_0020);
        wreg(`BBX_FDATA_OFS, 32'h0000_000f);
        wreg(`BBX_ACC_OFS, 32'h0000_0001);
        issue(ADD_ACCUMULATOR_WITH_FILE, 1'b0, 3'h0, 8'h20);
        rchk(`BBX_ACC_OFS, 32'h0000_0010);
        rchk(`BBX_FDATA_OFS, 32'h0000_000f);
        rchk(`BBX_STATUS_OFS, 32'h0000_0002);
        issue(ADD_ACCUMULATOR_WITH_FILE, 1'b1, 3'h0, 8'h20);
        rchk(`BBX_FDATA_OFS, 32'h0000_001f);
        rchk(`BBX_ACC_OFS, 32'h0000_0010);
        issue(AND_ACCUMULATOR_WITH_FILE, 1'b1, 3'h0, 8'h20);
        rchk(`BBX_FDATA_OFS, 32'h0000_0010);
        wreg(`BBX_ACC_OFS, 32'h0000_0001);
        wreg(`BBX_STATUS_OFS, 32'h0000_0003);
        issue(AND_ACCUMULATOR_WITH_FILE, 1'b0, 3'h0, 8'h20);
        rchk(`BBX_ACC_OFS, 32'h0000_0000);
        rchk(`BBX_STATUS_OFS, 32'h0000_0007);
    endtask

    // The top file address is the awkward case for the address field.
    task automatic t_bits;
        logic [7:0] v;
        v = 8'h00;
        wreg(`BBX_STATUS_OFS, 32'h0000_0005);
        wreg(`BBX_FADDR_OFS, 32'h0000_007f);
        wreg(`BBX_FDATA_OFS, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            v[i] = 1'b1;
            issue(SET_FILE_BIT, 1'b0, i[2:0], 8'h7f);
            rchk(`BBX_FDATA_OFS, {24'h0, v});
        end
        for (int i = 7; i >= 0; i--) begin
            v[i] = 1'b0;
            issue(CLEAR_FILE_BIT, 1'b0, i[2:0], 8'h7f);
            rchk(`BBX_FDATA_OFS, {24'h0, v});
        end
        rchk(`BBX_STATUS_OFS, 32'h0000_0005);
    endtask

    task automatic t_skip;
        wreg(`BBX_STATUS_OFS, 32'h0000_0000);
        wreg(`BBX_FADDR_OFS, 32'h0000_0030);
        wreg(`BBX_FDATA_OFS, 32'h0000_0004);
        wreg(`BBX_ACC_OFS, 32'h0000_0000);
        issue(SKIP_IF_BIT_ZERO, 1'b0, 3'h2, 8'h30);
        rchk(`BBX_STATUS_OFS, 32'h0000_0000);
        issue(ADD_LITERAL_TO_ACCUMULATOR, 1'b0, 3'h0, 8'h01);
        rchk(`BBX_ACC_OFS, 32'h0000_0001);
        issue(SKIP_IF_BIT_ZERO, 1'b0, 3'h0, 8'h30);
        rchk(`BBX_STATUS_OFS, 32'h0000_0008);
        issue(ADD_LITERAL_TO_ACCUMULATOR, 1'b0, 3'h0, 8'h01);
        rchk(`BBX_ACC_OFS, 32'h0000_0001);
        rchk(`BBX_STATUS_OFS, 32'h0000_0000);
        issue(SKIP_IF_BIT_ONE, 1'b0, 3'h0, 8'h30);
        issue(ADD_LITERAL_TO_ACCUMULATOR, 1'b0, 3'h0, 8'h01);
        rchk(`BBX_ACC_OFS, 32'h0000_0002);
        issue(SKIP_IF_BIT_ONE, 1'b0, 3'h2, 8'h30);
        rchk(`BBX_STATUS_OFS, 32'h0000_0008);
        issue(SET_FILE_BIT, 1'b0, 3'h7, 8'h30);
        rchk(`BBX_FDATA_OFS, 32'h0000_0004);
    endtask

    // The latch holds zero while the pins read A0, so a set bit must merge
    // with the pin level and not with the latch.
    task automatic t_pins;
        io_in <= 8'ha0;
        wreg(`BBX_FADDR_OFS, {25'h0, `BBX_IO_ADDR});
        rchk(`BBX_FDATA_OFS, 32'h0000_00a0);
        issue(SET_FILE_BIT, 1'b0, 3'h0, {1'b0, `BBX_IO_ADDR});
        chk({24'h0, io_out}, 32'h0000_00a1);
    endtask

    task automatic t_bad;
        logic [31:0] d;
        logic [1:0]  r;
        wr(8'h14, 32'h0000_00ff, r);
        chk({30'h0, r}, {30'h0, `BBX_RESP_SLVERR});
        rd(8'h14, d, r);
        chk(d, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, `BBX_RESP_SLVERR});
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The whole sequence needs well under two thousand cycles.
    initial begin
        #1_000_000;
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        t_reset();
        t_add_lit();
        t_and_lit();
        t_file();
        t_bits();
        t_skip();
        t_pins();
        t_bad();
        conclude();
    end
endmodule
